//--- logic/mmpc_defs.svh
// Offsets, field positions, reset values and timing counts of the pulse counter bank.
`ifndef MMPC_DEFS_SVH
`define MMPC_DEFS_SVH

`define MMPC_NUM_CNT        4
`define MMPC_CLK_PERIOD_PS  10000
`define MMPC_PERIOD_MIN_PS  93300
`define MMPC_PERIOD_MIN_CYC ((`MMPC_PERIOD_MIN_PS + `MMPC_CLK_PERIOD_PS - 1) / `MMPC_CLK_PERIOD_PS)
`define MMPC_PERIOD_MAX_S   1
`define MMPC_PERIOD_MAX_CYC (`MMPC_PERIOD_MAX_S * 64'h000000E8D4A51000 / `MMPC_CLK_PERIOD_PS)

`define MMPC_REG_CTRL       3'h0
`define MMPC_REG_INSEL      3'h1
`define MMPC_REG_GATESEL    3'h2
`define MMPC_REG_PERIOD     3'h3
`define MMPC_REG_VALUE      3'h4
`define MMPC_REG_STAMP      3'h5
`define MMPC_REG_LIVE       3'h6
`define MMPC_ADDR_TIME      8'h80

`define MMPC_CTRL_EN        0
`define MMPC_CTRL_MODE_LO   1
`define MMPC_CTRL_MODE_HI   2
`define MMPC_CTRL_RISE      3
`define MMPC_CTRL_FALL      4
`define MMPC_CTRL_OP_LO     5
`define MMPC_CTRL_OP_HI     6

`define MMPC_CTRL_RST       32'h00000008
`define MMPC_PERIOD_RST     32'h00002710
`define MMPC_SEL_TRIG_BASE  6'h20

`endif

//--- logic/mmpc_pkg.sv
// Types shared by the pulse counter bank.
package mmpc_pkg;
    typedef enum logic [1:0] {
        MMPC_FREE,
        MMPC_WINDOW,
        MMPC_WIN_PERIODIC,
        MMPC_STAMP
    } mmpc_mode_type;

    typedef enum logic [1:0] {
        MMPC_OP_NONE,
        MMPC_OP_ADD,
        MMPC_OP_SUB,
        MMPC_OP_RSVD
    } mmpc_op_type;
endpackage

//--- logic/mmpc_top.sv
// Bank of multi-mode pulse counters with APB registers and a result stream.
// Operation
// RULE_01: Four independent counters, each with own enable, mode, period, input, gate.
// RULE_02: Each counter counts every qualifying input pulse without loss.
// RULE_03: Count source selectable from trigger inputs or any of 32 digital lines.
// RULE_04: Counter outputs values only while enabled, behaving per selected mode.
// RULE_05: Periodic mode clears count each period start, outputs count at end.
// RULE_06: Window mode counts only between window rising and falling edges.
// RULE_07: Window mode outputs accumulated count when window falls.
// RULE_08: Windowed periodic holds counter and timer cleared while window low.
// RULE_09: Windowed periodic outputs only after window high longer than one period.
// RULE_10: Event stamp mode counts pulses and sends them with a time tag.
// RULE_11: Event stamp mode uses period as minimum hold-off between outputs.
// RULE_12: Pulses inside one hold-off window accumulate, output once at its end.
// RULE_13: Pair arithmetic adds or subtracts partner result; pairs are 1-2, 3-4.
// RULE_14: Every result carries a timestamp counting data clock cycles.
// RULE_15: Edge detection on rising, falling or both by two enable bits.
// RULE_16: Period ranges 93.3 ns to 1 s; used by periodic and hold-off.
// RULE_17: Inputs synchronised and edge detected so each edge counts once.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`include "mmpc_defs.svh"

// Register map: byte address is counter number times 0x20 plus register index times four.
// Index 0, control: bit 0 enable, bits 2:1 mode, bit 3 rising edge, bit 4 falling edge, bits 6:5 pair operation.
// Modes: 0 free periodic, 1 window, 2 windowed periodic, 3 event stamp.
// Pair operations: 0 none, 1 add partner, 2 subtract partner, 3 none.
// Index 1, input select: 0 to 31 pick a digital line, 32 to 35 a trigger pin; only bits 5:0 are kept and values above 35 clamp to 35.
// Index 2, gate select: 0 to 3 pick a trigger pin, 4 to 7 an internal trigger.
// Index 3, period in clock cycles; values outside the legal range are clamped where they are used.
// Index 4, last result after pair arithmetic, read only.
// Index 5, low word of the last result's stamp, read only.
// Index 6, live count of the running channel, read only.
// Address 0x80 returns the low word of the free-running time counter.
// Any other word address answers with an error, the two low address bits being ignored below 0x80; writes to read-only places are dropped silently.
// Every access takes one wait state; a write lands at the edge that completes the access.
// A result that is not yet sent is overwritten by the next one from the same channel.
// Disabling a channel clears its count and timer, but a pending result still leaves.
// The stamp is the time counter at capture, not the time of the first pulse.
// The lowest channel number wins when several results are pending in one cycle.

module mmpc_top #(
    parameter logic [31:0] PERIOD_MAX_CYC = 32'(`MMPC_PERIOD_MAX_CYC)
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [3:0]  trig_in,
    input  wire logic [31:0] parallel_digital_lines,
    input  wire logic [3:0]  awg_trig,
    output logic             res_valid,
    output logic [1:0]       res_index,
    output logic [31:0]      res_value,
    output logic [47:0]      res_stamp
);
    // Channel count and shortest legal period in clock cycles.
    localparam int N = `MMPC_NUM_CNT;
    localparam logic [31:0] PMIN = 32'(`MMPC_PERIOD_MIN_CYC);

    // Synchroniser stages for the pin inputs and the time counter.
    logic [3:0]  trig_m_reg;
    logic [3:0]  trig_s_reg;
    logic [31:0] dio_m_reg;
    logic [31:0] dio_s_reg;
    logic [47:0] time_reg;
    // Per-channel registers, live counts and captured results.
    logic [31:0] ctrl_reg   [N];
    logic [5:0]  insel_reg  [N];
    logic [2:0]  gsel_reg   [N];
    logic [31:0] period_reg [N];
    logic [31:0] live_reg   [N];
    logic [31:0] val_reg    [N];
    logic [47:0] stamp_reg  [N];
    // Hand-over between the channels and the result stream.
    logic [31:0] res_cnt    [N];
    logic [N-1:0] res_stb;
    logic [N-1:0] pend_reg;
    logic [N-1:0] take;
    // Bus decode.
    logic        acc_setup;
    logic        wr_ok;
    logic [2:0]  reg_sel;
    logic [1:0]  cnt_sel;
    logic        in_map;

    // Two-flop synchronisers for pins; only the second stage is read.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            trig_m_reg <= 4'h0;
            trig_s_reg <= 4'h0;
            dio_m_reg  <= 32'h00000000;
            dio_s_reg  <= 32'h00000000;
        end else begin
            trig_m_reg <= trig_in;
            trig_s_reg <= trig_m_reg; // see RULE_17
            dio_m_reg  <= parallel_digital_lines;
            dio_s_reg  <= dio_m_reg;  // see RULE_17
        end
    end

    // Free-running timestamp in data clock cycles.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            time_reg <= 48'h000000000000;
        end else begin
            time_reg <= time_reg + 48'h000000000001; // see RULE_14
        end
    end

    // APB decode: word address split into counter number and register index.
    assign reg_sel   = paddr[4:2];
    assign cnt_sel   = paddr[6:5];
    assign in_map    = (paddr[7] == 1'b0 && reg_sel <= `MMPC_REG_LIVE) || paddr == `MMPC_ADDR_TIME;
    assign acc_setup = psel && penable && !pready;
    assign wr_ok     = psel && penable && pready && pwrite && !paddr[7]; // Lands at the completing edge.

    // One wait state on every access; read data and error are registered.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_setup;
            pslverr <= acc_setup && !in_map;
            if (acc_setup && !pwrite) begin
                if (paddr == `MMPC_ADDR_TIME) begin
                    prdata <= time_reg[31:0];
                end else if (!in_map) begin
                    prdata <= 32'h00000000;
                end else begin
                    unique case (reg_sel)
                        `MMPC_REG_CTRL:    prdata <= ctrl_reg[cnt_sel];
                        `MMPC_REG_INSEL:   prdata <= {26'h0000000, insel_reg[cnt_sel]};
                        `MMPC_REG_GATESEL: prdata <= {29'h00000000, gsel_reg[cnt_sel]};
                        `MMPC_REG_PERIOD:  prdata <= period_reg[cnt_sel];
                        `MMPC_REG_VALUE:   prdata <= val_reg[cnt_sel];
                        `MMPC_REG_STAMP:   prdata <= stamp_reg[cnt_sel][31:0];
                        `MMPC_REG_LIVE:    prdata <= live_reg[cnt_sel];
                        default:           prdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // Lowest pending counter wins the result port.
    always_comb begin
        take = '0;
        for (int i = 0; i < N; i++) begin
            if (pend_reg[i] && take == '0) begin
                take[i] = 1'b1;
            end
        end
    end

    // Result stream: one-cycle valid carrying index, value and stamp.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            res_valid <= 1'b0;
            res_index <= 2'h0;
            res_value <= 32'h00000000;
            res_stamp <= 48'h000000000000;
        end else begin
            res_valid <= |take;
            for (int i = 0; i < N; i++) begin
                if (take[i]) begin
                    res_index <= 2'(i);
                    res_value <= val_reg[i];
                    res_stamp <= stamp_reg[i]; // see RULE_10
                end
            end
        end
    end

    // One counter channel per generate iteration.
    for (genvar g = 0; g < N; g++) begin : g_cnt
        // Decoded controls and selected inputs of this channel.
        mmpc_pkg::mmpc_mode_type mode;
        mmpc_pkg::mmpc_op_type   op;
        logic        en;
        logic        src;
        logic        gate;
        logic        pulse;
        logic        g_rise;
        logic        g_fall;
        logic        wrap;
        logic [31:0] per_eff;
        logic [31:0] part;
        // Channel state.
        logic        src_prev_reg;
        logic        gate_prev_reg;
        logic [31:0] cnt_reg;
        logic [31:0] tmr_reg;
        logic        busy_reg;
        logic        stb_reg;
        logic [31:0] hold_reg;

        assign mode = mmpc_pkg::mmpc_mode_type'(ctrl_reg[g][`MMPC_CTRL_MODE_HI:`MMPC_CTRL_MODE_LO]);
        assign op   = mmpc_pkg::mmpc_op_type'(ctrl_reg[g][`MMPC_CTRL_OP_HI:`MMPC_CTRL_OP_LO]);
        assign en   = ctrl_reg[g][`MMPC_CTRL_EN];
        // Source: digital line index below the trigger base, else a trigger input.
        assign src  = (insel_reg[g] < `MMPC_SEL_TRIG_BASE) ? dio_s_reg[insel_reg[g][4:0]]
                                                          : trig_s_reg[insel_reg[g][1:0]]; // see RULE_03
        assign gate = gsel_reg[g][2] ? awg_trig[gsel_reg[g][1:0]] : trig_s_reg[gsel_reg[g][1:0]];
        assign pulse = en && ((ctrl_reg[g][`MMPC_CTRL_RISE] && src && !src_prev_reg) ||
                              (ctrl_reg[g][`MMPC_CTRL_FALL] && !src && src_prev_reg)); // see RULE_15
        assign g_rise = gate && !gate_prev_reg;
        assign g_fall = !gate && gate_prev_reg;
        // Period clamped into the legal range.
        assign per_eff = (period_reg[g] < PMIN) ? PMIN :
                         (period_reg[g] > PERIOD_MAX_CYC) ? PERIOD_MAX_CYC : period_reg[g]; // see RULE_16
        assign wrap = (tmr_reg == per_eff - 32'h00000001);
        assign res_stb[g] = stb_reg;
        assign res_cnt[g] = hold_reg;
        assign live_reg[g] = cnt_reg;
        assign part = val_reg[g ^ 1];

        // Register writes for this channel.
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                ctrl_reg[g]   <= `MMPC_CTRL_RST;
                insel_reg[g]  <= 6'h00;
                gsel_reg[g]   <= 3'h0;
                period_reg[g] <= `MMPC_PERIOD_RST;
            end else if (wr_ok && cnt_sel == 2'(g)) begin
                unique case (reg_sel)
                    `MMPC_REG_CTRL:    ctrl_reg[g]   <= pwdata & 32'h0000007F; // see RULE_01
                    `MMPC_REG_INSEL:   insel_reg[g]  <= (pwdata[5:0] > 6'h23) ? 6'h23 : pwdata[5:0];
                    `MMPC_REG_GATESEL: gsel_reg[g]   <= pwdata[2:0];
                    `MMPC_REG_PERIOD:  period_reg[g] <= pwdata;
                    default:           ;
                endcase
            end
        end

        // Edge detectors on the synchronised source and on the gate, which is synchronised only when it is a trigger pin.
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                src_prev_reg  <= 1'b0;
                gate_prev_reg <= 1'b0;
            end else begin
                src_prev_reg  <= src;  // see RULE_17
                gate_prev_reg <= gate;
            end
        end

        // Counting engine; stb_reg marks a finished result for one cycle.
        always_ff @(posedge mclk) begin
            if (sys_rst || !en) begin
                cnt_reg  <= 32'h00000000;
                tmr_reg  <= 32'h00000000;
                busy_reg <= 1'b0;
                stb_reg  <= 1'b0;      // see RULE_04
                hold_reg <= 32'h00000000;
            end else begin
                stb_reg <= 1'b0;
                unique case (mode)
                    mmpc_pkg::MMPC_FREE: begin
                        tmr_reg <= wrap ? 32'h00000000 : tmr_reg + 32'h00000001;
                        if (wrap) begin
                            hold_reg <= cnt_reg + 32'(pulse); // see RULE_05
                            stb_reg  <= 1'b1;
                            cnt_reg  <= 32'h00000000;
                        end else begin
                            cnt_reg <= cnt_reg + 32'(pulse); // see RULE_02
                        end
                    end
                    mmpc_pkg::MMPC_WINDOW: begin
                        if (g_rise) begin
                            cnt_reg <= 32'(pulse); // see RULE_06
                        end else if (g_fall) begin
                            hold_reg <= cnt_reg;  // see RULE_07
                            stb_reg  <= 1'b1;
                        end else if (gate) begin
                            cnt_reg <= cnt_reg + 32'(pulse); // see RULE_06
                        end
                    end
                    mmpc_pkg::MMPC_WIN_PERIODIC: begin
                        if (!gate) begin
                            cnt_reg <= 32'h00000000; // see RULE_08
                            tmr_reg <= 32'h00000000;
                        end else if (wrap) begin
                            hold_reg <= cnt_reg + 32'(pulse); // see RULE_09
                            stb_reg  <= 1'b1;
                            cnt_reg  <= 32'h00000000;
                            tmr_reg  <= 32'h00000000;
                        end else begin
                            cnt_reg <= cnt_reg + 32'(pulse);
                            tmr_reg <= tmr_reg + 32'h00000001;
                        end
                    end
                    mmpc_pkg::MMPC_STAMP: begin
                        if (!busy_reg) begin
                            if (pulse) begin
                                busy_reg <= 1'b1; // see RULE_10
                                cnt_reg  <= 32'h00000001;
                                tmr_reg  <= 32'h00000000;
                            end
                        end else if (wrap) begin
                            hold_reg <= cnt_reg + 32'(pulse); // see RULE_12
                            stb_reg  <= 1'b1;
                            busy_reg <= 1'b0;  // see RULE_11
                            cnt_reg  <= 32'h00000000;
                        end else begin
                            cnt_reg <= cnt_reg + 32'(pulse); // see RULE_12
                            tmr_reg <= tmr_reg + 32'h00000001;
                        end
                    end
                endcase
            end
        end

        // Result capture with pair arithmetic, stamp and pending flag (set beats clear).
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                val_reg[g]   <= 32'h00000000;
                stamp_reg[g] <= 48'h000000000000;
                pend_reg[g]  <= 1'b0;
            end else begin
                if (res_stb[g]) begin
                    unique case (op)
                        mmpc_pkg::MMPC_OP_ADD: val_reg[g] <= res_cnt[g] + part; // see RULE_13
                        mmpc_pkg::MMPC_OP_SUB: val_reg[g] <= res_cnt[g] - part; // see RULE_13
                        default:               val_reg[g] <= res_cnt[g];
                    endcase
                    stamp_reg[g] <= time_reg; // see RULE_14
                    pend_reg[g]  <= 1'b1;
                end else if (take[g]) begin
                    pend_reg[g] <= 1'b0;
                end
            end
        end
    end
endmodule

//--- test/mmpc_pulse_src.sv
// Pulse and gate sources that drive the inputs of the counter bank.
module mmpc_pulse_src (
    input  wire logic   mclk,
    output logic [31:0] lines,
    output logic [3:0]  trig
);
    timeunit 1ns;
    timeprecision 1ps;

    // All lines rest low until a burst or a gate is asked for.
    initial begin
        lines = 32'h0;
        trig = 4'h0;
    end

    // Sends n pulses on one line; every level lasts two cycles or more to stay inside the count rate.
    task automatic burst(input int idx, input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            lines[idx] <= 1'b1;
            repeat (hi) @(posedge mclk);
            lines[idx] <= 1'b0;
            repeat (lo) @(posedge mclk);
        end
    endtask

    // Sets one gate level and lets an edge pass.
    task automatic gate(input int idx, input logic v);
        trig[idx] <= v;
        @(posedge mclk);
    endtask
endmodule

//--- test/mmpc_props.sv
// Checker that watches the ports of the counter bank.
module mmpc_props (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        res_valid,
    input wire logic [31:0] res_value,
    input wire logic [47:0] res_stamp
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [47:0] cyc_reg;

    // Counts clock cycles since reset, in step with the block's time counter.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cyc_reg <= 48'h0;
        end else begin
            cyc_reg <= cyc_reg + 48'h1;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Bus answers, error codes and the result stream.
    rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !pready && !res_valid && prdata == 32'h0)
        else $error("outputs active after reset");
    ready_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    ready_quiet_a: assert property (!(psel && penable) |=> !pready)
        else $error("ready without access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_map_a: assert property (pready && paddr[1:0] == 2'h0 |->
        pslverr == (paddr[7] ? paddr != 8'h80 : paddr[4:2] == 3'h7))
        else $error("error flag does not match map");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data moved without a read");
    value_hold_a: assert property (!res_valid |-> $stable(res_value))
        else $error("result moved without valid");
    stamp_age_a: assert property (res_valid |-> res_stamp < cyc_reg - 48'h1)
        else $error("stamp not taken before the result left");
endmodule

bind mmpc_top mmpc_props u_props (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
    .pslverr, .res_valid, .res_value, .res_stamp);

//--- test/multi_mode_pulse_counter_test.sv
// Self-checking bench for the pulse counter bank.
module multi_mode_pulse_counter_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] lines;
    logic [3:0]  trig;
    logic        res_valid;
    logic [1:0]  res_index;
    logic [31:0] res_value;
    logic [47:0] res_stamp;
    logic [31:0] seed = 32'hFCFC8C9C;
    logic [31:0] rd;
    logic [31:0] t;
    logic        er;
    logic [81:0] q[$];
    logic [81:0] r;
    logic [47:0] last_stamp;
    int          failures = 0;
    int          samples_checked = 0;
    int          v0;
    int          n;
    int          adj;
    int          sum;

    mmpc_top #(.PERIOD_MAX_CYC(32'hC8)) dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .trig_in(trig), .parallel_digital_lines(lines), .awg_trig(4'h0),
        .res_valid, .res_index, .res_value, .res_stamp);
    mmpc_pulse_src src (.mclk, .lines, .trig);

    // Clock of 10 ns.
    always #5 mclk = ~mclk;

    // Collects each result of the stream with its stamp.
    always @(posedge mclk) begin
        if (res_valid === 1'b1) begin
            q.push_back({res_index, res_value, res_stamp});
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One bus transfer; the request stands until ready is seen.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            failures++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Waits a bounded time for the next result.
    task automatic get_res(input int lim);
        for (int k = 0; k < lim && q.size() == 0; k++) @(posedge mclk);
        if (q.size() == 0) begin
            failures++;
            end_sim();
        end
        r = q.pop_front();
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        // Reset value, unmapped word, period limits, read-only places and time.
        apb(8'h00, 1'b0, 32'h0);
        chk(rd, 32'h8);
        apb(8'h1C, 1'b0, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(8'h0C, 1'b1, 32'h5);
        apb(8'h0C, 1'b0, 32'h0);
        chk(rd, 32'h5);
        apb(8'h0C, 1'b1, 32'h3E8);
        apb(8'h0C, 1'b0, 32'h0);
        chk(rd, 32'h3E8);
        apb(8'h10, 1'b1, 32'h55);
        apb(8'h10, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(8'h80, 1'b0, 32'h0);
        t = rd;
        apb(8'h80, 1'b0, 32'h0);
        chk(rd - t, 32'h4);
        $display("register test done");
        // Window mode on counter 0 with rise, fall and both edges.
        for (int e = 0; e < 3; e++) begin
            apb(8'h00, 1'b1, 32'(e * 8) + 32'h0B);
            n = 1 + rnd() % 8;
            src.gate(0, 1'b1);
            repeat (4) @(posedge mclk);
            src.burst(0, n, 2 + rnd() % 3, 2 + rnd() % 3);
            repeat (4) @(posedge mclk);
            src.gate(0, 1'b0);
            get_res(20);
            v0 = n * (e == 2 ? 2 : 1);
            chk(r[81:48], {2'h0, 32'(v0)});
            $display("window test %0d done", e);
        end
        // Event stamp mode on counter 1 with every pair operation.
        apb(8'h2C, 1'b1, 32'h32);
        for (int op = 0; op < 4; op++) begin
            adj = op == 1 ? v0 : op == 2 ? -v0 : 0;
            apb(8'h20, 1'b1, 32'(op * 32) + 32'h0F);
            n = 1 + rnd() % 4;
            src.burst(0, n, 2, 3);
            get_res(80);
            chk(r[81:48], {2'h1, 32'(n + adj)});
            last_stamp = r[47:0];
            src.burst(0, 1, 2, 2);
            get_res(80);
            chk(r[81:48], {2'h1, 32'(1 + adj)});
            chk(r[47:0] - last_stamp >= 48'h32, 1'b1);
            $display("stamp test %0d done", op);
        end
        // Free running counter 2, then disabled.
        apb(8'h44, 1'b1, 32'h1);
        apb(8'h4C, 1'b1, 32'h5);
        apb(8'h40, 1'b1, 32'h9);
        get_res(40);
        q.delete();
        n = 1 + rnd() % 8;
        src.burst(1, n, 2, 2);
        repeat (45) @(posedge mclk);
        apb(8'h40, 1'b1, 32'h8);
        repeat (5) @(posedge mclk);
        last_stamp = 48'h0;
        sum = 0;
        while (q.size() > 0) begin
            r = q.pop_front();
            if (last_stamp != 48'h0) begin
                chk(r[47:0] - last_stamp, 48'hA);
            end
            last_stamp = r[47:0];
            sum += r[79:48];
        end
        chk(sum, n);
        repeat (60) @(posedge mclk);
        chk(q.size(), 0);
        $display("free test done");
        // Windowed periodic counter 3: short gate gives nothing, long gate gives a cleared count.
        apb(8'h64, 1'b1, 32'h2);
        apb(8'h68, 1'b1, 32'h1);
        apb(8'h6C, 1'b1, 32'h14);
        apb(8'h60, 1'b1, 32'hD);
        src.burst(2, 3, 2, 2);
        src.gate(1, 1'b1);
        repeat (12) @(posedge mclk);
        src.gate(1, 1'b0);
        repeat (20) @(posedge mclk);
        chk(q.size(), 0);
        src.gate(1, 1'b1);
        get_res(40);
        chk(r[81:48], {2'h3, 32'h0});
        $display("gated periodic test done");
        end_sim();
    end
endmodule
